// ### mdr_dma.sv
// multichannel dma engine with request router, staging fifo and wishbone slave
// ****************************************************************
// staging fifo
// ****************************************************************
//
// The register addresses and the Wishbone slave port were left to the implementer.
module mdr_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [AW-1:0] wp_nx = (wp == AW'(D - 1)) ? '0 : AW'(wp + 1'b1);
  wire [AW-1:0] rp_nx = (rp == AW'(D - 1)) ? '0 : AW'(rp + 1'b1);
  assign in_ready_o = (cnt != (AW + 1)'(D));
  assign out_valid_o = (cnt != '0);
  assign out_data_o = mem[rp];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= wp_nx;
      if (pop) rp <= rp_nx;
      if (push && !pop) cnt <= cnt + 1'b1;
      else if (pop && !push) cnt <= cnt - 1'b1;
    end
  end
endmodule : mdr_fifo

// Behaviour
// - every word is read from the source address, then written to the destination
// - source, destination and byte count are separate per-channel descriptor words
// - channel count is a parameter: sixteen by default, eight as option
// - each channel owns a 32-byte descriptor held in local storage
// - descriptor defines an inner loop nested within an outer loop
// - inner loop moves exactly the minor byte count, partial last word masked
// - outer loop repeats inner loops until the iteration count is used up
// - software picks fixed-priority or round-robin channel arbitration
// - completion raises a channel interrupt only when its enable is set
// - router takes 63 request inputs, any routable to any channel
// - each router channel selects its peripheral request source
// - disabled router channel passes no request
// - per-channel hardware request enable gates peripheral-started service
// - a completed descriptor may name a further descriptor to load next
module mdr_dma
  import mdr_pkg::*;
#(
  parameter int NCH = NCH_DEF,
  parameter int NSRC = NSRC_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mdr_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [NSRC-1:0] periph_req_i,
  output mdr_mem_req_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output logic [NCH-1:0] irq_o
);
  localparam int CW = $clog2(NCH);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] tcd [NCH][TCD_WORDS];
  logic [RTR_W-1:0] rtr [NCH];
  logic ctrl_rr;
  logic [NCH-1:0] hreq_en;
  logic [NCH-1:0] done;
  logic [NCH-1:0] start_pend;
  logic [NSRC-1:0] s1;
  logic [NSRC-1:0] s2;
  logic [NSRC-1:0] s3;
  logic [NSRC-1:0] lvl;
  logic [NCH-1:0] routed;
  mdr_state_t state;
  logic [CW-1:0] cur;
  logic [CW-1:0] last;
  logic [31:0] sa;
  logic [31:0] da;
  logic [31:0] soff;
  logic [31:0] doff;
  logic [31:0] rd_left;
  logic [31:0] wr_left;
  logic [31:0] fifo_dout;
  logic fifo_in_ready;
  logic fifo_out_valid;
  // ****************************************************************
  // request inputs: three-stage synchroniser, change taken when stages 2 and 3 agree
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= periph_req_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) lvl[gi] <= 1'b0;
        else if (s2[gi] == s3[gi]) lvl[gi] <= s3[gi];
      end
    end
  endgenerate
  // ****************************************************************
  // request router
  // ****************************************************************
  // unused source codes read as an idle request
  wire [SRC_SPACE-1:0] lvl_ext = SRC_SPACE'(lvl);
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_rtr
      wire [SRC_IDX_W-1:0] src = rtr[gi][SRC_IDX_W-1:0];
      assign routed[gi] = rtr[gi][RTR_EN] && lvl_ext[src];
    end
  endgenerate
  // ****************************************************************
  // register decode
  // ****************************************************************
  wire [11:0] a = wb_i.adr[11:0];
  wire wb_hit = wb_i.cyc && wb_i.stb && !wb_ack_o;
  wire wb_wr = wb_hit && wb_i.we;
  wire [11:0] tcd_off = a - OFS_TCD;
  wire [11:0] rtr_off = a - OFS_RTR;
  wire in_tcd = (a >= OFS_TCD) && (a < OFS_TCD + 12'(NCH * TCD_BYTES));
  wire in_rtr = (a >= OFS_RTR) && (a < OFS_RTR + 12'(NCH * 4));
  wire [CW-1:0] tcd_ch = tcd_off[CW+4:5];
  wire [2:0] tcd_w = tcd_off[4:2];
  wire [CW-1:0] rtr_ch = rtr_off[CW+1:2];
  wire [31:0] stat_val = {1'b1 ^ (state == ST_IDLE), 31'(cur)};
  // unmapped offsets read zero and ignore writes
  wire [31:0] rd_val =
    (a == OFS_CTRL) ? 32'(ctrl_rr) :
    (a == OFS_HREQ) ? 32'(hreq_en) :
    (a == OFS_DONE) ? 32'(done) :
    (a == OFS_START) ? 32'(start_pend) :
    (a == OFS_STAT) ? stat_val :
    in_rtr ? 32'(rtr[rtr_ch]) :
    in_tcd ? tcd[tcd_ch][tcd_w] : 32'h0000_0000;
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction : merge
  wire [31:0] hreq_wv = merge(32'(hreq_en), wb_i.dat, wb_i.sel);
  wire [31:0] rtr_wv = merge(32'(rtr[rtr_ch]), wb_i.dat, wb_i.sel);
  wire [31:0] tcd_wv = merge(tcd[tcd_ch][tcd_w], wb_i.dat, wb_i.sel);
  // ****************************************************************
  // arbitration
  // ****************************************************************
  function automatic logic [CW:0] pick(input logic [NCH-1:0] p, input logic rr,
                                       input logic [CW-1:0] lst);
    logic [CW-1:0] g;
    logic f;
    logic [CW-1:0] idx;
    g = '0;
    f = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      idx = rr ? CW'(int'(lst) + 1 + i) : CW'(i);
      if (!f && p[idx]) begin
        g = idx;
        f = 1'b1;
      end
    end
    return {f, g};
  endfunction : pick
  wire [NCH-1:0] pending = (hreq_en & routed) | start_pend;
  wire [CW:0] arb = pick(pending, ctrl_rr, last);
  wire grant = (state == ST_IDLE) && arb[CW];
  wire [CW-1:0] gch = arb[CW-1:0];
  // ****************************************************************
  // engine decisions
  // ****************************************************************
  wire do_read = (state == ST_XFER) && (rd_left != '0) && fifo_in_ready;
  wire do_write = (state == ST_XFER) && !do_read && fifo_out_valid;
  wire xfer_end = (state == ST_XFER) && !do_read && !fifo_out_valid && (wr_left == '0);
  wire rd_ack = (state == ST_RWAIT) && mem_ack_i;
  wire wr_ack = (state == ST_WWAIT) && mem_ack_i;
  wire minor_end = (state == ST_MINOR_END);
  wire [31:0] citer = tcd[cur][TW_CITER];
  wire [31:0] csr = tcd[cur][TW_CSR];
  wire major_end = minor_end && (citer <= 32'h0000_0001);
  wire [CW-1:0] link = csr[CSR_LINK_LSB +: CW];
  // last word of an odd-sized inner loop writes only its remaining bytes
  wire [3:0] wsel = (wr_left >= WORD_BYTES) ? SEL_ALL : 4'(SEL_ALL >> (3'h4 - wr_left[2:0]));
  wire [31:0] rd_next = (rd_left >= WORD_BYTES) ? rd_left - WORD_BYTES : '0;
  wire [31:0] wr_next = (wr_left >= WORD_BYTES) ? wr_left - WORD_BYTES : '0;
  wire [NCH-1:0] grant_oh = grant ? NCH'(1) << gch : '0;
  wire [NCH-1:0] done_set = major_end ? NCH'(1) << cur : '0;
  wire [NCH-1:0] start_set = (wb_wr && a == OFS_START) ? wb_i.dat[NCH-1:0] : '0;
  wire [NCH-1:0] done_clr = (wb_wr && a == OFS_DONE) ? wb_i.dat[NCH-1:0] : '0;
  // ****************************************************************
  // bus slave and control registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_rr <= 1'b0;
      hreq_en <= '0;
      done <= '0;
      start_pend <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_i.we) wb_dat_o <= rd_val;
      if (wb_wr && a == OFS_CTRL && wb_i.sel[0]) ctrl_rr <= wb_i.dat[CTRL_RR];
      if (wb_wr && a == OFS_HREQ) hreq_en <= hreq_wv[NCH-1:0];
      // a completion landing on the clearing write stays set
      done <= (done & ~done_clr) | done_set;
      start_pend <= (start_pend & ~grant_oh) | start_set;
    end
  end
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_regs
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rtr[gi] <= '0;
          irq_o[gi] <= 1'b0;
        end else begin
          if (wb_wr && in_rtr && rtr_ch == CW'(gi)) rtr[gi] <= rtr_wv[RTR_W-1:0];
          irq_o[gi] <= done[gi] && tcd[gi][TW_CSR][CSR_INTEN];
        end
      end
    end
  endgenerate
  // ****************************************************************
  // descriptor store: engine write-back takes precedence over software
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        for (int w = 0; w < TCD_WORDS; w++) tcd[c][w] <= '0;
      end
    end else if (major_end && csr[CSR_LINKEN]) begin
      tcd[cur] <= tcd[link];
    end else if (minor_end) begin
      tcd[cur][TW_SADDR] <= sa;
      tcd[cur][TW_DADDR] <= da;
      tcd[cur][TW_CITER] <= major_end ? tcd[cur][TW_BITER] : citer - 32'h0000_0001;
    end else if (wb_wr && in_tcd) begin
      tcd[tcd_ch][tcd_w] <= tcd_wv;
    end
  end
  // ****************************************************************
  // transfer engine
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cur <= '0;
      last <= CW'(NCH - 1);
      sa <= '0;
      da <= '0;
      soff <= '0;
      doff <= '0;
      rd_left <= '0;
      wr_left <= '0;
      mem_o <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (grant) begin
            cur <= gch;
            last <= gch;
            sa <= tcd[gch][TW_SADDR];
            da <= tcd[gch][TW_DADDR];
            soff <= tcd[gch][TW_SOFF];
            doff <= tcd[gch][TW_DOFF];
            rd_left <= tcd[gch][TW_NBYTES];
            wr_left <= tcd[gch][TW_NBYTES];
            state <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (do_read) begin
            mem_o <= '{cyc: 1'b1, we: 1'b0, addr: sa, sel: SEL_ALL, wdata: '0};
            state <= ST_RWAIT;
          end else if (do_write) begin
            mem_o <= '{cyc: 1'b1, we: 1'b1, addr: da, sel: wsel, wdata: fifo_dout};
            state <= ST_WWAIT;
          end else if (xfer_end) begin
            state <= ST_MINOR_END;
          end
        end
        ST_RWAIT: begin
          if (rd_ack) begin
            mem_o <= '0;
            sa <= sa + soff;
            rd_left <= rd_next;
            state <= ST_XFER;
          end
        end
        ST_WWAIT: begin
          if (wr_ack) begin
            mem_o <= '0;
            da <= da + doff;
            wr_left <= wr_next;
            state <= ST_XFER;
          end
        end
        ST_MINOR_END: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // reads run ahead of writes; a full fifo stalls further reads
  mdr_fifo #(
    .W(DW),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rd_ack),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mem_rdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(wr_ack),
    .out_data_o(fifo_dout)
  );
endmodule : mdr_dma

// ### mdr_pkg.sv
// package: register map, descriptor layout, bus carriers and engine states
package mdr_pkg;
  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NCH_DEF = 16;
  localparam int NSRC_DEF = 63;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int DW = 32;
  localparam int TCD_WORDS = 8;
  localparam int TCD_BYTES = 32;
  localparam int RTR_W = 8;
  localparam int SRC_IDX_W = 6;
  localparam int SRC_SPACE = 64;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [3:0] SEL_ALL = 4'hF;
  // ****************************************************************
  // register offsets (byte addresses, low 12 bits decoded)
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_HREQ = 12'h004;
  localparam logic [11:0] OFS_DONE = 12'h008;
  localparam logic [11:0] OFS_START = 12'h00C;
  localparam logic [11:0] OFS_STAT = 12'h010;
  localparam logic [11:0] OFS_RTR = 12'h100;
  localparam logic [11:0] OFS_TCD = 12'h200;
  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int CTRL_RR = 0;
  localparam int RTR_EN = 7;
  localparam int STAT_BUSY = 31;
  localparam logic [2:0] TW_SADDR = 3'h0;
  localparam logic [2:0] TW_DADDR = 3'h1;
  localparam logic [2:0] TW_NBYTES = 3'h2;
  localparam logic [2:0] TW_SOFF = 3'h3;
  localparam logic [2:0] TW_DOFF = 3'h4;
  localparam logic [2:0] TW_CITER = 3'h5;
  localparam logic [2:0] TW_BITER = 3'h6;
  localparam logic [2:0] TW_CSR = 3'h7;
  localparam int CSR_INTEN = 0;
  localparam int CSR_LINKEN = 1;
  localparam int CSR_LINK_LSB = 8;
  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mdr_wb_req_t;
  typedef struct packed {
    logic cyc;
    logic we;
    logic [31:0] addr;
    logic [3:0] sel;
    logic [31:0] wdata;
  } mdr_mem_req_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_XFER, ST_RWAIT, ST_WWAIT, ST_MINOR_END
  } mdr_state_t;
endpackage : mdr_pkg

// ### mdr_dma_asserts.sv
// concurrent checks on the engine's register bus and memory master ports
module mdr_dma_asserts import mdr_pkg::*; #(
  parameter int NCH = NCH_DEF,
  parameter int NSRC = NSRC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mdr_wb_req_t wb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [NSRC-1:0] periph_req_i,
  input wire mdr_mem_req_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic [NCH-1:0] irq_o
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_lat; wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_quiet; !(wb_i.cyc && wb_i.stb) |=> !wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
  property p_mem_hold; mem_o.cyc && !mem_ack_i |=> mem_o.cyc && $stable(mem_o); endproperty
  property p_mem_drop; mem_o.cyc && mem_ack_i |=> !mem_o.cyc; endproperty
  property p_rd_sel; mem_o.cyc && !mem_o.we |-> mem_o.sel == SEL_ALL; endproperty
  property p_wr_sel; mem_o.cyc && mem_o.we |-> mem_o.sel inside {4'h1, 4'h3, 4'h7, 4'hF};
  endproperty
  a_ack_lat: assert property (p_ack_lat)
    else $error("register access not acknowledged one cycle after it was taken");
  a_ack_quiet: assert property (p_ack_quiet)
    else $error("acknowledge without a request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data changed without acknowledge");
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request changed before acknowledge");
  a_mem_drop: assert property (p_mem_drop)
    else $error("memory request not released after acknowledge");
  a_rd_sel: assert property (p_rd_sel)
    else $error("source read is not a full word");
  a_wr_sel: assert property (p_wr_sel)
    else $error("destination write has an illegal byte mask");
  c_read: cover property (mem_o.cyc && !mem_o.we && mem_ack_i);
  c_part: cover property (mem_o.cyc && mem_o.we && mem_o.sel == 4'h3 && mem_ack_i);
  c_irq: cover property ($rose(irq_o[0]));
endmodule : mdr_dma_asserts

bind mdr_dma mdr_dma_asserts #(.NCH(NCH), .NSRC(NSRC)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .periph_req_i(periph_req_i),
  .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .irq_o(irq_o));

// ### mdr_mem_model.sv
// memory slave model: varying wait states, address-derived read words, byte-lane writes
module mdr_mem_model import mdr_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mdr_mem_req_t req_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wq [$];
  logic [31:0] m;
  int cnt = 0;
  int nacc = 0;
  initial ack_o = 1'b0;
  initial rdata_o = '0;
  // ****************************************************************
  // responder
  // ****************************************************************
  // wait states cycle 0..3 so both prompt and slow answers occur
  always @(posedge clk_i) begin
    if (rst_i || !req_i.cyc || ack_o) begin
      ack_o <= 1'b0;
      cnt <= 0;
      rdata_o <= ~rdata_o;
    end else if (cnt < nacc % 4) begin
      cnt <= cnt + 1;
      rdata_o <= ~rdata_o;
    end else begin
      ack_o <= 1'b1;
      nacc <= nacc + 1;
      if (req_i.we) begin
        m = mem.exists(req_i.addr) ? mem[req_i.addr] : '0;
        for (int b = 0; b < 4; b++) if (req_i.sel[b]) m[8*b +: 8] = req_i.wdata[8*b +: 8];
        mem[req_i.addr] = m;
        wq.push_back(req_i.addr);
      end else rdata_o <= req_i.addr ^ 32'h5A5A_0000;
    end
  end
endmodule : mdr_mem_model

// ### mdr_dma_tb_top.sv
// testbench: register access, software-started, routed and arbitrated transfers
module mdr_dma_tb_top import mdr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mdr_wb_req_t wb_i = '0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o, rd;
  logic [62:0] periph_req_i = '0;
  mdr_mem_req_t mem_o;
  logic mem_ack_i;
  logic [31:0] mem_rdata_i;
  logic [15:0] irq_o;
  int err_count = 0;
  int check_count = 0;
  int base;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  mdr_dma dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .periph_req_i(periph_req_i), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .irq_o(irq_o));
  mdr_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_o), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i));
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  // waits for the acknowledge however long it takes; only the watchdog ends a hang
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {20'h0, a}, sel: SEL_ALL, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    `CHK(rd, e)
  endtask : rdc
  function automatic logic [11:0] ta(input int ch, input logic [2:0] w);
    return OFS_TCD + 12'(ch * 32) + 12'({w, 2'b00});
  endfunction : ta
  task automatic setup(input int ch, input logic [31:0] sa, da, nb, it, csr);
    logic [31:0] v [8];
    v = '{sa, da, nb, WORD_BYTES, WORD_BYTES, it, it, csr};
    for (int w = 0; w < 8; w++) wr(ta(ch, 3'(w)), v[w]);
  endtask : setup
  // polls until n writes were seen and the engine is idle, or a done mask is set
  task automatic settle(input int n, input logic [31:0] m);
    do begin
      wb(1'b0, (m == 0) ? OFS_STAT : OFS_DONE, '0);
    end while ((m == 0) ? (mem_u.wq.size() < n || rd[STAT_BUSY] !== 1'b0)
      : ((rd & m) !== m));
  endtask : settle
  task automatic wrap_up;
    $display("Comparisons: %0d, mismatches: %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(OFS_CTRL, '0);
    rdc(ta(5, TW_CSR), '0);
    wr(12'h050, 32'hFFFF_FFFF);
    rdc(12'h050, '0);
    setup(0, 32'h0000_1000, 32'h0000_2000, 32'h6, 32'h2, 32'h1);
    wr(OFS_START, 32'h1);
    settle(2, '0);
    rdc(ta(0, TW_CITER), 32'h1);
    rdc(ta(0, TW_SADDR), 32'h0000_1008);
    rdc(OFS_DONE, '0);
    wr(OFS_START, 32'h1);
    settle(4, 32'h1);
    `CHK(irq_o[0], 1'b1)
    rdc(ta(0, TW_CITER), 32'h2);
    rdc(ta(0, TW_DADDR), 32'h0000_2010);
    for (int i = 0; i < 4; i++) `CHK(mem_u.mem[32'h2000 + 4 * i], ((32'h1000 + 4 * i) ^
      32'h5A5A_0000) & ((i % 2) ? 32'h0000_FFFF : 32'hFFFF_FFFF))
    wr(OFS_DONE, 32'h1);
    `CHK(irq_o[0], 1'b0)
    setup(3, 32'h0000_3000, 32'h0000_4000, 32'h4, 32'h1, 32'h0);
    wr(OFS_RTR + 12'hC, 32'h85);
    periph_req_i[5] <= 1'b1;
    repeat (30) @(posedge clk_i);
    rdc(OFS_DONE, '0);
    wr(OFS_RTR + 12'hC, 32'h05);
    wr(OFS_HREQ, 32'h8);
    repeat (30) @(posedge clk_i);
    rdc(OFS_DONE, '0);
    wr(OFS_RTR + 12'hC, 32'h85);
    settle(0, 32'h8);
    periph_req_i[5] <= 1'b0;
    wr(OFS_HREQ, '0);
    settle(0, '0);
    `CHK(mem_u.mem[32'h4000], 32'h0000_3000 ^ 32'h5A5A_0000)
    `CHK(irq_o[3], 1'b0)
    wr(OFS_DONE, 32'hFFFF);
    // fixed priority: channel 1 beats channel 2, then round robin after 2 favours 3
    for (int r = 0; r < 2; r++) begin
      setup(1 + r, 32'h0000_5000, 32'h0000_6000, 32'h4, 32'h1, 32'h0);
      setup(2 + r, 32'h0000_5100, 32'h0000_7000, 32'h4, 32'h1, 32'h0);
      base = mem_u.wq.size();
      wr(OFS_CTRL, 32'(r));
      wr(OFS_START, 32'(6 << r));
      settle(0, 32'(6 << r));
      `CHK(mem_u.wq[base], r ? 32'h0000_7000 : 32'h0000_6000)
      wr(OFS_DONE, 32'hFFFF);
    end
    // linked descriptor: channel 4 finishes and takes over the descriptor of slot 5
    setup(4, 32'h0000_8000, 32'h0000_9000, 32'h4, 32'h1, 32'h0000_0503);
    setup(5, 32'h0000_A000, 32'h0000_B000, 32'h8, 32'h3, 32'h0);
    wr(OFS_START, 32'h10);
    settle(0, 32'h10);
    `CHK(mem_u.mem[32'h9000], 32'h0000_8000 ^ 32'h5A5A_0000)
    rdc(ta(4, TW_SADDR), 32'h0000_A000);
    rdc(ta(4, TW_CITER), 32'h3);
    `CHK(irq_o[4], 1'b0)
    wrap_up();
  end
endmodule : mdr_dma_tb_top
